// [bench/fic_host.sv]
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Host controller: clock runs only inside frames, data moves between edges
module fic_host (
	output var fic_pkg::fic_link_s link_o
);
	import fic_pkg::*;

	initial begin
		link_o = '{cs_n: 1'b1, sclk: 1'b0, dq: 8'hA5};
	end

	task automatic beat(input logic [7:0] v);
		link_o.dq = v;
		#40 link_o.sclk = ~link_o.sclk;
		#40;
	endtask

	task automatic send(input logic [31:0] a, input logic [7:0] d [32], input bit chk,
			input logic [7:0] pf, input logic [7:0] cf, input int cs);
		logic [7:0] c;
		c = 8'h00;
		link_o.cs_n = 1'b0;
		beat(8'h3C);
		beat(8'hC3);
		for (int i = 0; i < 4; i++) begin
			beat(a[31-8*i -: 8]);
		end
		if (chk) begin
			beat(a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0] ^ pf);
			beat(8'h5A);
		end
		for (int i = 0; i < 32; i++) begin
			beat(d[i]);
			c = c ^ d[i];
			if (chk && i % cs == cs - 1) begin
				beat(c ^ ((i == 31) ? cf : 8'h00));
				beat(~c);
				c = 8'h00;
			end
		end
		#40 link_o.cs_n = 1'b1;
		// Released lines must not keep the last value
		link_o.dq = ~link_o.dq;
	endtask
endmodule

`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
	import fic_pkg::*;

	logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]        wb_adr_i, prog_byte_o, m_cfg;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, prog_addr_o, rs, exp_addr, m_fa;
	logic              hw_reset_n_i, soft_reset_i, inband_reset_i, clear_error_cmd_i;
	logic              octal_ddr_i, prog_cmd_i, prog_addr_valid_o, prog_byte_valid_o;
	logic              prog_abort_o, enc_valid_i, enc_programmed_i, enc_valid_o, enc_abort_o;
	logic              rd_valid_i, rd_valid_o, err_o, err_oe_o;
	logic [FIC_DW-1:0] enc_data_i, rd_data_o;
	logic [FIC_CW-1:0] enc_check_o;
	fic_link_s         link_i;
	fic_rd_s           rd_i;
	logic [7:0]        exp_q [$];
	int                err_total, compares, n_addr, n_abt, e_addr, e_abt, m_cnt;
	bit                m_dbl, m_par, m_crc, m_fset, m_pin;

	fic_top u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_i(link_i), .hw_reset_n_i(hw_reset_n_i),
		.soft_reset_i(soft_reset_i), .inband_reset_i(inband_reset_i),
		.clear_error_cmd_i(clear_error_cmd_i), .octal_ddr_i(octal_ddr_i), .prog_cmd_i(prog_cmd_i),
		.prog_addr_o(prog_addr_o), .prog_addr_valid_o(prog_addr_valid_o),
		.prog_byte_o(prog_byte_o), .prog_byte_valid_o(prog_byte_valid_o),
		.prog_abort_o(prog_abort_o), .enc_valid_i(enc_valid_i), .enc_data_i(enc_data_i),
		.enc_programmed_i(enc_programmed_i), .enc_check_o(enc_check_o),
		.enc_valid_o(enc_valid_o), .enc_abort_o(enc_abort_o), .rd_valid_i(rd_valid_i),
		.rd_i(rd_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .err_o(err_o),
		.err_oe_o(err_oe_o)
	);
	fic_host u_host (.link_o(link_i));

	always #10 clk_i = ~clk_i;

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	task automatic ck(input string nm, input logic [127:0] e, input logic [127:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %0h got %0h", nm, e, g);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wb(input bit we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) ck("wb_ack", 1, 0);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rr(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		ck(nm, e, q);
	endtask

	task automatic mclr(input bit full);
		{m_cnt, m_dbl, m_par, m_crc, m_fa, m_fset, m_pin} = '0;
		m_cfg = full ? 8'h40 : (m_cfg & 8'h7F);
	endtask

	// Register file against the reference state
	task automatic regs();
		rr("config", 8'h2C, m_cfg);
		rr("status", 8'h30, {1'b0, 4'(m_cnt), m_dbl, m_par, m_crc});
		for (int i = 0; i < 4; i++) rr("first_addr", 8'(8'h50 + 4*i), m_fa[8*i +: 8]);
		ck("err_oe", m_pin, err_oe_o);
		ck("err_o", 0, err_o);
	endtask

	// k: 0 clear command, 1 software, 2 in-band, 3 hardware pin
	task automatic pulse(input int k);
		case (k)
			0: clear_error_cmd_i <= 1'b1;
			1: soft_reset_i <= 1'b1;
			2: inband_reset_i <= 1'b1;
			default: hw_reset_n_i <= 1'b0;
		endcase
		repeat ((k == 3) ? 8 : 1) @(posedge clk_i);
		{clear_error_cmd_i, soft_reset_i, inband_reset_i, hw_reset_n_i} <= 4'h1;
		repeat (6) @(posedge clk_i);
		mclr(k != 0);
	endtask

	task automatic frame(input bit oct, input bit en, input bit prg, input logic [7:0] pf,
			input logic [7:0] cf, input logic [1:0] sz);
		logic [7:0] d [32];
		bit chk;
		chk = oct && en;
		// Fresh aligned chunks each frame, never a partly written one again
		exp_addr = rnd() & 32'hFFFFFFF0;
		for (int i = 0; i < 32; i++) d[i] = 8'(rnd());
		m_cfg = {2'h1, sz, en, 3'h0};
		wr(8'h2C, m_cfg);
		octal_ddr_i <= oct;
		prog_cmd_i <= prg;
		if (prg && !(chk && pf != 0)) begin
			e_addr++;
			for (int i = 0; i < 32; i++) exp_q.push_back(d[i]);
		end
		if (prg && chk && (pf != 0 || cf != 0)) begin
			e_abt++;
			m_par |= (pf != 0);
			m_crc |= (pf == 0);
		end
		u_host.send(exp_addr, d, chk, pf, cf, 16 << sz);
		repeat (10) @(posedge clk_i);
		ck("addr_count", e_addr, n_addr);
		ck("abort_count", e_abt, n_abt);
		ck("bytes_left", 0, exp_q.size());
		regs();
	endtask

	task automatic ecc(input int nf);
		logic [127:0] d;
		logic [31:0] a;
		logic [8:0] c;
		int b0, b1;
		bit q;
		d = {rnd(), rnd(), rnd(), rnd()};
		a = rnd();
		b0 = rnd() % 128;
		b1 = (b0 + 1 + rnd() % 127) % 128;
		enc_data_i <= d;
		enc_valid_i <= 1'b1;
		@(posedge clk_i);
		enc_valid_i <= 1'b0;
		@(posedge clk_i);
		ck("enc_valid", 1, enc_valid_o);
		c = enc_check_o;
		rd_i <= '{addr: a, data: d ^ (128'h1 << b0) ^ ((nf == 2) ? (128'h1 << b1) : '0), check: c};
		rd_valid_i <= 1'b1;
		@(posedge clk_i);
		rd_valid_i <= 1'b0;
		@(posedge clk_i);
		q = (nf == 2) || !m_cfg[2];
		m_cnt = (m_cnt < 15) ? m_cnt + 1 : 15;
		m_dbl |= (nf == 2);
		if (q && !m_fset) m_fa = a & 32'hFFFFFFF0;
		m_fset |= q;
		m_pin |= q;
		ck("rd_valid", 1, rd_valid_o);
		if (nf == 1) ck("rd_data", d, rd_data_o);
		ck("err_oe", m_pin, err_oe_o);
	endtask

	always @(posedge clk_i) begin
		if (prog_addr_valid_o === 1'b1) begin
			n_addr++;
			ck("prog_addr", exp_addr, prog_addr_o);
		end
		if (prog_byte_valid_o === 1'b1)
			ck("prog_byte", (exp_q.size() > 0) ? exp_q.pop_front() : 9'h100, prog_byte_o);
		if (prog_abort_o === 1'b1) n_abt++;
	end

	initial begin
		#1000000;
		err_total++;
		summarize();
	end

	initial begin
		{clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		{soft_reset_i, inband_reset_i, clear_error_cmd_i, octal_ddr_i, prog_cmd_i} = '0;
		{enc_valid_i, enc_programmed_i, enc_data_i, rd_valid_i, rd_i} = '0;
		{err_total, compares, n_addr, n_abt, e_addr, e_abt} = '0;
		wb_sel_i = 4'hF;
		hw_reset_n_i = 1'b1;
		rst_i = 1'b1;
		rs = 32'd22742;
		mclr(1'b1);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		regs();
		rr("unmapped", 8'h00, 8'h00);
		wr(8'h30, 8'hFF);
		regs();
		frame(1, 1, 1, 8'h00, 8'h00, 2'h0);
		frame(1, 1, 1, 8'h00, 8'h00, 2'h1);
		frame(1, 1, 1, 8'h04, 8'h00, 2'h0);
		frame(1, 1, 1, 8'h00, 8'h80, 2'h0);
		frame(0, 1, 1, 8'h00, 8'h00, 2'h0);
		frame(1, 0, 1, 8'h00, 8'h00, 2'h0);
		frame(1, 1, 0, 8'h00, 8'h00, 2'h0);
		pulse(0);
		regs();
		ecc(1);
		ecc(2);
		ecc(1);
		regs();
		pulse(0);
		m_cfg = 8'h44;
		wr(8'h2C, m_cfg);
		ecc(1);
		ecc(2);
		for (int i = 0; i < 16; i++) ecc(1);
		regs();
		enc_programmed_i <= 1'b1;
		enc_valid_i <= 1'b1;
		@(posedge clk_i);
		{enc_programmed_i, enc_valid_i} <= 2'b00;
		@(posedge clk_i);
		ck("enc_abort", 1, enc_abort_o);
		ck("enc_valid", 0, enc_valid_o);
		m_cfg[7] = 1'b1;
		regs();
		m_cfg[7] = 1'b0;
		wr(8'h2C, m_cfg);
		regs();
		for (int k = 0; k < 4; k++) begin
			m_cfg = 8'h4C;
			wr(8'h2C, m_cfg);
			ecc(2);
			pulse(k);
			regs();
		end
		summarize();
	end
endmodule

`default_nettype wire

// [design/fic_pkg.sv]
package fic_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address on the bus is four times the index
	localparam logic [5:0] FIC_IDX_CONFIG = 6'h0B;
	localparam logic [5:0] FIC_IDX_STATUS = 6'h0C;
	localparam logic [5:0] FIC_IDX_FADDR0 = 6'h14;
	localparam logic [5:0] FIC_IDX_FADDR1 = 6'h15;
	localparam logic [5:0] FIC_IDX_FADDR2 = 6'h16;
	localparam logic [5:0] FIC_IDX_FADDR3 = 6'h17;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FIC_CFG_REPROG = 7;
	localparam int FIC_CFG_CSIZE  = 4;
	localparam int FIC_CFG_ENABLE = 3;
	localparam int FIC_CFG_EVSEL  = 2;
	localparam int FIC_ST_DBL     = 2;
	localparam int FIC_ST_PAR     = 1;
	localparam int FIC_ST_CRC     = 0;
	localparam int FIC_ST_CNT     = 3;
	localparam int FIC_CNT_W      = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  FIC_CFG_RST   = 8'h40;
	localparam logic [31:0] FIC_FADDR_RST = 32'h00000000;

	////////////////////////////////////////////////////////////////////////////////
	// Chunk geometry and link framing
	localparam int          FIC_DW         = 128;
	localparam int          FIC_CW         = 9;
	localparam int          FIC_CW_POS     = 136;
	localparam logic [7:0]  FIC_CHUNK_BASE = 8'h10;
	localparam logic [1:0]  FIC_CMD_LAST   = 2'h1;
	localparam logic [1:0]  FIC_ADDR_LAST  = 2'h3;
	localparam logic [3:0]  FIC_CNT_MAX    = 4'hF;

	typedef enum {
		LS_IDLE,
		LS_CMD,
		LS_ADDR,
		LS_PAR,
		LS_PAD,
		LS_DATA,
		LS_CRC,
		LS_SKIP
	} fic_link_st_e;

	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [7:0] dq;
	} fic_link_s;

	typedef struct packed {
		logic       rst_n;
		fic_link_s  link;
	} fic_pins_s;

	typedef struct packed {
		logic [31:0]       addr;
		logic [FIC_DW-1:0] data;
		logic [FIC_CW-1:0] check;
	} fic_rd_s;

endpackage

// [design/fic_top.sv]
// What this block does
// - Each 16-byte chunk carries its own single-correct double-detect code.
// - Reprogramming a programmed chunk is aborted and config bit 7 set.
// - Status bits [2:0] give error type, bits [6:3] count ECC events.
// - Chunk address of first qualifying ECC event is kept in bytes 14h-17h.
// - Clear command, software, hardware, in-band or power-up reset default all; the clear command keeps config bits 6:0.
// - A 256-byte page holds sixteen 16-byte chunks in ascending order.
// - Address parity and data CRC checks run only in octal DDR.
// - Config bit 3 enables both checks; both are even parity.
// - Parity bit n is the XOR of all address bits on line n.
// - Parity mismatch aborts the command and sets status bit 1.
// - CRC bit n is the XOR of all chunk bits on line n.
// - CRC mismatch aborts the program and sets status bit 0.
// - Open-drain error pin pulls low on ECC event until reset or clear.
// - Error pin goes low within two clocks of the chunk's first data.
// - Event select bit 2 set: pin and address react to double errors only.
// - Status bit 2 shows a double-bit detection.
// - Clear command also defaults counter, first address and status bits.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module fic_top (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [7:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire fic_pkg::fic_link_s        link_i,
	input  wire logic                      hw_reset_n_i,
	input  wire logic                      soft_reset_i,
	input  wire logic                      inband_reset_i,
	input  wire logic                      clear_error_cmd_i,
	input  wire logic                      octal_ddr_i,
	input  wire logic                      prog_cmd_i,
	output logic      [31:0]               prog_addr_o,
	output logic                           prog_addr_valid_o,
	output logic      [7:0]                prog_byte_o,
	output logic                           prog_byte_valid_o,
	output logic                           prog_abort_o,
	input  wire logic                      enc_valid_i,
	input  wire logic [fic_pkg::FIC_DW-1:0] enc_data_i,
	input  wire logic                      enc_programmed_i,
	output logic      [fic_pkg::FIC_CW-1:0] enc_check_o,
	output logic                           enc_valid_o,
	output logic                           enc_abort_o,
	input  wire logic                      rd_valid_i,
	input  wire fic_pkg::fic_rd_s          rd_i,
	output logic      [fic_pkg::FIC_DW-1:0] rd_data_o,
	output logic                           rd_valid_o,
	output logic                           err_o,
	output logic                           err_oe_o
);
	import fic_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Check code over one chunk: XOR of codeword positions of set data bits
	function automatic logic [7:0] ecc_syn(input logic [FIC_DW-1:0] d);
		logic [7:0] s;
		int         j;
		s = 8'h00;
		j = 0;
		for (int k = 1; k <= FIC_CW_POS; k++) begin
			if ((k & (k - 1)) != 0) begin
				if (d[j]) begin
					s = s ^ k[7:0];
				end
				j = j + 1;
			end
		end
		return s;
	endfunction

	function automatic logic [FIC_DW-1:0] ecc_fix(input logic [FIC_DW-1:0] d,
		input logic [7:0] s);
		logic [FIC_DW-1:0] f;
		int                j;
		f = d;
		j = 0;
		for (int k = 1; k <= FIC_CW_POS; k++) begin
			if ((k & (k - 1)) != 0) begin
				if (k[7:0] == s) begin
					f[j] = ~f[j];
				end
				j = j + 1;
			end
		end
		return f;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin sampling: three stages, a change counts once stages two and three agree
	fic_pins_s syn1;
	fic_pins_s syn2;
	fic_pins_s syn3;
	fic_pins_s filt;
	fic_pins_s next_filt;
	fic_pins_s pins;
	fic_pins_s pins_rst;

	assign pins     = '{rst_n: hw_reset_n_i, link: link_i};
	assign pins_rst = '{rst_n: 1'b1, link: '{cs_n: 1'b1, sclk: 1'b0, dq: 8'h00}};

	always_comb begin
		next_filt = (syn2 & syn3) | (filt & (syn2 ^ syn3));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			syn1 <= pins_rst;
			syn2 <= pins_rst;
			syn3 <= pins_rst;
			filt <= pins_rst;
		end else begin
			syn1 <= pins;
			syn2 <= syn1;
			syn3 <= syn2;
			filt <= next_filt;
		end
	end

	logic vol_clr;
	logic err_clr;
	logic sclk_edge;

	assign vol_clr   = soft_reset_i | inband_reset_i | ~filt.rst_n;
	assign err_clr   = vol_clr | clear_error_cmd_i;
	assign sclk_edge = next_filt.link.sclk ^ filt.link.sclk;

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0]           cfg;
	logic                 dbl_flag;
	logic                 par_flag;
	logic                 crc_flag;
	logic [FIC_CNT_W-1:0] ecc_cnt;
	logic [31:0]          faddr;
	logic                 captured;
	logic [7:0]           csize;

	assign csize = FIC_CHUNK_BASE << cfg[FIC_CFG_CSIZE +: 2];

	////////////////////////////////////////////////////////////////////////////////
	// Program frame on the link
	fic_link_st_e lst;
	fic_link_st_e next_lst;
	logic [1:0]   beat;
	logic [1:0]   next_beat;
	logic [7:0]   acc;
	logic [7:0]   next_acc;
	logic [7:0]   cnt;
	logic [7:0]   next_cnt;
	logic         chk;
	logic         next_chk;
	logic [31:0]  next_prog_addr;
	logic         next_prog_addr_valid;
	logic [7:0]   next_prog_byte;
	logic         next_prog_byte_valid;
	logic         next_prog_abort;
	logic         par_fail;
	logic         crc_fail;
	logic [7:0]   dq;

	assign dq = next_filt.link.dq;

	always_comb begin
		next_lst             = lst;
		next_beat            = beat;
		next_acc             = acc;
		next_cnt             = cnt;
		next_chk             = chk;
		next_prog_addr       = prog_addr_o;
		next_prog_addr_valid = 1'b0;
		next_prog_byte       = prog_byte_o;
		next_prog_byte_valid = 1'b0;
		next_prog_abort      = 1'b0;
		par_fail             = 1'b0;
		crc_fail             = 1'b0;
		if (next_filt.link.cs_n) begin
			next_lst = LS_IDLE;
		end else if (sclk_edge) begin
			case (lst)
				LS_IDLE: begin
					next_lst  = LS_CMD;
					next_beat = 2'h1;
				end
				LS_CMD: begin
					if (beat == FIC_CMD_LAST) begin
						next_lst  = prog_cmd_i ? LS_ADDR : LS_SKIP;
						next_chk  = octal_ddr_i & cfg[FIC_CFG_ENABLE];
						next_beat = 2'h0;
						next_acc  = 8'h00;
					end else begin
						next_beat = beat + 2'h1;
					end
				end
				LS_ADDR: begin
					next_prog_addr = {prog_addr_o[23:0], dq};
					next_acc       = acc ^ dq;
					next_beat      = beat + 2'h1;
					next_cnt       = 8'h00;
					if (beat == FIC_ADDR_LAST) begin
						next_lst             = chk ? LS_PAR : LS_DATA;
						next_prog_addr_valid = ~chk;
					end
				end
				LS_PAR: begin
					// Even parity: the byte brings the running XOR to zero
					if ((acc ^ dq) != 8'h00) begin
						par_fail        = 1'b1;
						next_prog_abort = 1'b1;
						next_lst        = LS_SKIP;
					end else begin
						next_prog_addr_valid = 1'b1;
						next_lst             = LS_PAD;
					end
					next_acc = 8'h00;
				end
				LS_PAD: begin
					next_lst = LS_DATA;
				end
				LS_DATA: begin
					next_prog_byte       = dq;
					next_prog_byte_valid = 1'b1;
					next_acc             = acc ^ dq;
					next_cnt             = cnt + 8'h01;
					if (chk && (next_cnt == csize)) begin
						next_lst = LS_CRC;
					end
				end
				LS_CRC: begin
					// Bytes already passed on; the abort tells the array to drop them
					if ((acc ^ dq) != 8'h00) begin
						crc_fail        = 1'b1;
						next_prog_abort = 1'b1;
						next_lst        = LS_SKIP;
					end else begin
						next_lst = LS_PAD;
					end
					next_acc = 8'h00;
					next_cnt = 8'h00;
				end
				LS_SKIP: begin
					next_lst = LS_SKIP;
				end
				default: begin
					next_lst = LS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lst               <= LS_IDLE;
			beat              <= 2'h0;
			acc               <= 8'h00;
			cnt               <= 8'h00;
			chk               <= 1'b0;
			prog_addr_o       <= 32'h00000000;
			prog_addr_valid_o <= 1'b0;
			prog_byte_o       <= 8'h00;
			prog_byte_valid_o <= 1'b0;
			prog_abort_o      <= 1'b0;
		end else begin
			lst               <= next_lst;
			beat              <= next_beat;
			acc               <= next_acc;
			cnt               <= next_cnt;
			chk               <= next_chk;
			prog_addr_o       <= next_prog_addr;
			prog_addr_valid_o <= next_prog_addr_valid;
			prog_byte_o       <= next_prog_byte;
			prog_byte_valid_o <= next_prog_byte_valid;
			prog_abort_o      <= next_prog_abort;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Chunk code: encode on program, check and correct on read
	logic [7:0]        enc_syn;
	logic [7:0]        rd_syn;
	logic              rd_single;
	logic              rd_double;
	logic              ecc_event;
	logic              qual_event;
	logic              reprog;

	assign enc_syn    = ecc_syn(enc_data_i);
	assign rd_syn     = ecc_syn(rd_i.data) ^ rd_i.check[7:0];
	assign rd_single  = ^{rd_i.data, rd_i.check};
	assign rd_double  = ~rd_single & (rd_syn != 8'h00);
	assign ecc_event  = rd_valid_i & (rd_single | rd_double);
	assign qual_event = rd_valid_i & (rd_double | (rd_single & ~cfg[FIC_CFG_EVSEL]));
	assign reprog     = enc_valid_i & enc_programmed_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enc_check_o <= '0;
			enc_valid_o <= 1'b0;
			enc_abort_o <= 1'b0;
			rd_data_o   <= '0;
			rd_valid_o  <= 1'b0;
		end else begin
			enc_check_o <= {^{enc_data_i, enc_syn}, enc_syn};
			enc_valid_o <= enc_valid_i & ~enc_programmed_i;
			enc_abort_o <= reprog;
			rd_data_o   <= rd_single ? ecc_fix(rd_i.data, rd_syn) : rd_i.data;
			rd_valid_o  <= rd_valid_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after the request, write lands on the ack edge
	logic        next_ack;
	logic [31:0] next_dat;
	logic        wr_cfg;
	logic [5:0]  idx;

	assign idx    = wb_adr_i[7:2];
	assign wr_cfg = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0] &
		(idx == FIC_IDX_CONFIG);

	always_comb begin
		next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		next_dat = 32'h00000000;
		case (idx)
			FIC_IDX_CONFIG: next_dat[7:0] = cfg;
			FIC_IDX_STATUS: next_dat[7:0] = {1'b0, ecc_cnt, dbl_flag, par_flag, crc_flag};
			FIC_IDX_FADDR0: next_dat[7:0] = faddr[7:0];
			FIC_IDX_FADDR1: next_dat[7:0] = faddr[15:8];
			FIC_IDX_FADDR2: next_dat[7:0] = faddr[23:16];
			FIC_IDX_FADDR3: next_dat[7:0] = faddr[31:24];
			default:        next_dat = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_ack ? next_dat : wb_dat_o;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Config, status, first-event address and error pin
	logic [7:0]           next_cfg;
	logic                 next_dbl;
	logic                 next_par;
	logic                 next_crc;
	logic [FIC_CNT_W-1:0] next_cnt_ecc;
	logic [31:0]          next_faddr;
	logic                 next_captured;
	logic                 next_err;

	always_comb begin
		next_cfg = cfg;
		if (wr_cfg) begin
			// Abort flag is cleared by writing zero, other bits are plain storage
			next_cfg = {cfg[FIC_CFG_REPROG] & wb_dat_i[FIC_CFG_REPROG], wb_dat_i[6:0]};
		end
		if (err_clr) begin
			next_cfg[FIC_CFG_REPROG] = 1'b0;
		end
		if (vol_clr) begin
			next_cfg = FIC_CFG_RST;
		end
		if (reprog) begin
			next_cfg[FIC_CFG_REPROG] = 1'b1;
		end
		next_dbl      = (dbl_flag & ~err_clr) | (rd_valid_i & rd_double);
		next_par      = (par_flag & ~err_clr) | par_fail;
		next_crc      = (crc_flag & ~err_clr) | crc_fail;
		next_cnt_ecc  = err_clr ? '0 : ecc_cnt;
		if (ecc_event && (next_cnt_ecc != FIC_CNT_MAX)) begin
			next_cnt_ecc = next_cnt_ecc + 4'h1;
		end
		next_captured = captured & ~err_clr;
		next_faddr    = err_clr ? FIC_FADDR_RST : faddr;
		if (qual_event && !next_captured) begin
			next_faddr    = {rd_i.addr[31:4], 4'h0};
			next_captured = 1'b1;
		end
		next_err = (err_oe_o & ~err_clr) | qual_event;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg      <= FIC_CFG_RST;
			dbl_flag <= 1'b0;
			par_flag <= 1'b0;
			crc_flag <= 1'b0;
			ecc_cnt  <= '0;
			faddr    <= FIC_FADDR_RST;
			captured <= 1'b0;
			err_oe_o <= 1'b0;
		end else begin
			cfg      <= next_cfg;
			dbl_flag <= next_dbl;
			par_flag <= next_par;
			crc_flag <= next_crc;
			ecc_cnt  <= next_cnt_ecc;
			faddr    <= next_faddr;
			captured <= next_captured;
			err_oe_o <= next_err;
		end
	end

	// Open drain: only ever pulls low
	assign err_o = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	err_latency_a: assert property (qual_event |=> err_oe_o)
		else $error("error pin late after qualifying read");
	err_hold_a: assert property (err_oe_o && !err_clr |=> err_oe_o)
		else $error("error pin released without clear");
	err_single_a: assert property (rd_valid_i && rd_single && cfg[FIC_CFG_EVSEL] &&
		!err_oe_o ##1 !rd_valid_i |-> !err_oe_o)
		else $error("error pin reacted to single error in double-only mode");
	dbl_status_a: assert property (rd_valid_i && rd_double |=> dbl_flag)
		else $error("double detection not shown in status");
	reprog_abort_a: assert property (reprog |=> enc_abort_o && !enc_valid_o &&
		cfg[FIC_CFG_REPROG])
		else $error("reprogram not aborted");
	par_abort_a: assert property (par_fail |=> prog_abort_o && par_flag &&
		!prog_addr_valid_o)
		else $error("parity mismatch not aborted");
	crc_abort_a: assert property (crc_fail |=> prog_abort_o && crc_flag)
		else $error("crc mismatch not aborted");
	check_gate_a: assert property (lst == LS_PAR || lst == LS_CRC |-> chk)
		else $error("check byte expected while checks off");
	clear_all_a: assert property (clear_error_cmd_i && !rd_valid_i |=> !err_oe_o &&
		ecc_cnt == 4'h0 && !captured && !par_flag && !crc_flag)
		else $error("clear left error state");
	ecc_count_a: assert property (ecc_event && !err_clr && ecc_cnt != FIC_CNT_MAX |=>
		ecc_cnt == $past(ecc_cnt) + 4'h1)
		else $error("ecc counter did not advance");
	faddr_keep_a: assert property (captured && !err_clr |=> $stable(faddr))
		else $error("first event address overwritten");

	single_fix_c: cover property (rd_valid_i && rd_single);
	double_det_c: cover property (rd_valid_i && rd_double ##1 err_oe_o);
	par_fail_c: cover property (par_fail);
	crc_pass_c: cover property (lst == LS_CRC && sclk_edge && !crc_fail);

endmodule

`default_nettype wire
